// file: ebt_edge_sync.sv
/*
 * Two-flop synchroniser with edge detection for the external event input.
 * Assumes the input may change at any time relative to pclk.
 */
`timescale 1ns/10ps
module ebt_edge_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw input and detected edges
  input  wire logic din,
  output logic      rise,
  output logic      fall
);

  // ==========================================================================
  // Synchroniser and edge detector
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // First flop feeds only the second; edges come from later stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule

// file: ebt_event_src.sv
/*
 * Partner model: external event source feeding the timer's event input.
 * Assumes the bench raises go with a pulse count and lowers go between runs.
 */
`timescale 1ns/10ps
module ebt_event_src (
  // Clock and control
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] npulses,
  // Event line and status
  output logic            event_input_pin,
  output logic            done
);
  logic [10:0] ph_reg;

  // ==========================================================================
  // Phase counter: each pulse is 4 cycles low then 4 high, idle low
  always_ff @(posedge pclk) begin
    if (!go) begin
      ph_reg <= 11'h000;
    end else if (!done) begin
      ph_reg <= ph_reg + 11'h001;
    end
  end

  // Pulses give one rising and one falling edge each
  // Done only counts while a run is requested, so a stale count is never seen
  assign done            = go && (ph_reg == {npulses, 3'b000});
  assign event_input_pin = go && !done && ph_reg[2];
endmodule

// file: ebt_pkg.sv
/*
 * Package for the eight-bit event timer: register offsets, field positions,
 * reset values, clock select codes and prescaler width.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package ebt_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] EBT_CLKSEL_OFS = 8'h00; // count_clock_select
  localparam logic [7:0] EBT_MODE_OFS   = 8'h04; // timer_mode_control
  localparam logic [7:0] EBT_CMP_OFS    = 8'h08; // compare_value
  localparam logic [7:0] EBT_CNT_OFS    = 8'h0C; // up_counter, read only
  localparam logic [7:0] EBT_STAT_OFS   = 8'h10; // status, write 1 to clear

  // ==========================================================================
  // Mode and status register fields
  localparam int EBT_RUN_BIT     = 7;
  localparam int EBT_PWM_BIT     = 6;
  localparam int EBT_CASCADE_BIT = 4;
  localparam int EBT_LVS_BIT     = 3;
  localparam int EBT_LVR_BIT     = 2;
  localparam int EBT_INV_BIT     = 1;
  localparam int EBT_OE_BIT      = 0;
  localparam int EBT_STAT_MATCH_BIT = 0;

  // ==========================================================================
  // Reset values and widths
  localparam logic [7:0] EBT_MODE_RST   = 8'h00;
  localparam logic [2:0] EBT_CLKSEL_RST = 3'h0;
  localparam logic [7:0] EBT_CMP_RST    = 8'h00;
  localparam int         EBT_PRE_W      = 8;

  // ==========================================================================
  // Count clock select codes
  typedef enum logic [2:0] {
    EBT_SEL_FALL  = 3'b000,
    EBT_SEL_RISE  = 3'b001,
    EBT_SEL_DIV1  = 3'b010,
    EBT_SEL_DIV2  = 3'b011,
    EBT_SEL_DIV4  = 3'b100,
    EBT_SEL_DIV64 = 3'b101,
    EBT_SEL_DIV256 = 3'b110,
    EBT_SEL_OTHER = 3'b111
  } ebt_clksel_e;

endpackage

// file: ebt_prescaler.sv
/*
 * Free-running prescaler giving one-cycle ticks at pclk/2, /4, /64, /256.
 * Assumes it runs from reset and never stops.
 */
`timescale 1ns/10ps
module ebt_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Tick outputs
  output logic      tick2,
  output logic      tick4,
  output logic      tick64,
  output logic      tick256
);

  // ==========================================================================
  // Divider counter
  logic [W-1:0] div_reg;

  // Counts every edge and wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // A tick when the low bits are all ones
  assign tick2   = &div_reg[0:0];
  assign tick4   = &div_reg[1:0];
  assign tick64  = &div_reg[5:0];
  assign tick256 = &div_reg[7:0];

endmodule

// file: ebt_timer.sv
/*
 * Eight-bit timer/event counter channel with APB register access.
 * Holds count clock selection, counter, compare, output flip-flop and PWM.
 * Assumes a single pclk domain, an APB master and synchronous pin inputs;
 * the external event input is still synchronised before use.
 */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module ebt_timer
  import ebt_pkg::*;
#(
  parameter logic CASCADE_CAPABLE = 1'b1 // Second channel carries cascade bit
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and events
  input  wire logic        event_input_pin,
  input  wire logic        other_timer_match_event,
  output logic             timer_output_pin,
  output logic             compare_match_interrupt,
  output logic             cascade_select
);
  import ebt_pkg::*;

  // ==========================================================================
  // Registers
  logic [2:0] clksel_reg;
  logic [7:0] mode_reg;
  logic [7:0] cmp_reg;
  logic [7:0] cnt_reg;
  logic       outff_reg;
  logic       pwm_act_reg;
  logic       match_sticky_reg;
  logic       run_last_reg;

  // Field views
  logic run_bit;
  logic pwm_bit;
  logic lvs_bit;
  logic lvr_bit;
  logic inv_bit;
  logic oe_bit;
  assign run_bit = mode_reg[EBT_RUN_BIT];
  assign pwm_bit = mode_reg[EBT_PWM_BIT];
  assign lvs_bit = mode_reg[EBT_LVS_BIT];
  assign lvr_bit = mode_reg[EBT_LVR_BIT];
  assign inv_bit = mode_reg[EBT_INV_BIT];
  assign oe_bit  = mode_reg[EBT_OE_BIT];

  // ==========================================================================
  // APB decode: zero-wait, every address answers, unmapped reads zero
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == EBT_CLKSEL_OFS) || (paddr == EBT_MODE_OFS) ||
                   (paddr == EBT_CMP_OFS) || (paddr == EBT_CNT_OFS) ||
                   (paddr == EBT_STAT_OFS);

  // ==========================================================================
  // Input synchronisation and prescaler
  logic ev_rise;
  logic ev_fall;
  logic t2;
  logic t4;
  logic t64;
  logic t256;

  ebt_edge_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (event_input_pin),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  ebt_prescaler #(.W(EBT_PRE_W)) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .tick2   (t2),
    .tick4   (t4),
    .tick64  (t64),
    .tick256 (t256)
  );

  // Count tick selection
  logic tick;
  always_comb begin
    case (ebt_clksel_e'(clksel_reg))
      EBT_SEL_FALL:   tick = ev_fall;
      EBT_SEL_RISE:   tick = ev_rise;
      EBT_SEL_DIV1:   tick = 1'b1;
      EBT_SEL_DIV2:   tick = t2;
      EBT_SEL_DIV4:   tick = t4;
      EBT_SEL_DIV64:  tick = t64;
      EBT_SEL_DIV256: tick = t256;
      EBT_SEL_OTHER:  tick = other_timer_match_event;
      default:        tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Match and overflow events
  logic match;
  logic ovf;
  assign match = run_bit & tick & (cnt_reg == cmp_reg);
  assign ovf   = run_bit & tick & (cnt_reg == 8'hFF);

  // PWM ends as the count steps onto the compare value, so N gives N active clocks
  logic pwm_end;
  assign pwm_end = run_bit & tick & (8'(cnt_reg + 8'h01) == cmp_reg);

  // Control registers, reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_reg <= EBT_CLKSEL_RST;
      mode_reg   <= EBT_MODE_RST;
      cmp_reg    <= EBT_CMP_RST;
    end else if (wr_en) begin
      if (paddr == EBT_CLKSEL_OFS) begin
        clksel_reg <= pwdata[2:0];
      end
      if (paddr == EBT_MODE_OFS) begin
        mode_reg <= {pwdata[7:6], 1'b0, pwdata[4] & CASCADE_CAPABLE, pwdata[3:0]};
      end
      if (paddr == EBT_CMP_OFS) begin
        cmp_reg <= pwdata[7:0];
      end
    end
  end

  // Counter: cleared when stopped, zeroed on match outside PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (!run_bit) begin
      cnt_reg <= 8'h00;
    end else if (tick) begin
      if (!pwm_bit && cnt_reg == cmp_reg) begin
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // Level bits act at once; inversion on match when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outff_reg <= 1'b0;
    end else if (lvs_bit && !lvr_bit) begin
      outff_reg <= 1'b1;
    end else if (lvr_bit && !lvs_bit) begin
      outff_reg <= 1'b0;
    end else if (!pwm_bit && inv_bit && match) begin
      outff_reg <= ~outff_reg;
    end
  end

  // PWM phase: active from overflow to match, inactive when stopped
  // End wins over overflow so a compare value of zero never goes active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_act_reg <= 1'b0;
    end else if (!run_bit || !pwm_bit) begin
      pwm_act_reg <= 1'b0;
    end else if (pwm_end) begin
      pwm_act_reg <= 1'b0;
    end else if (ovf) begin
      pwm_act_reg <= 1'b1;
    end
  end

  // Interrupt pulse and sticky status; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_interrupt <= 1'b0;
      match_sticky_reg        <= 1'b0;
    end else begin
      compare_match_interrupt <= match & ~pwm_bit;
      if (match && !pwm_bit) begin
        match_sticky_reg <= 1'b1;
      end else if (wr_en && paddr == EBT_STAT_OFS && pwdata[EBT_STAT_MATCH_BIT]) begin
        match_sticky_reg <= 1'b0;
      end
    end
  end

  // Output pin and cascade select, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin <= 1'b0;
      cascade_select   <= 1'b0;
      run_last_reg     <= 1'b0;
    end else begin
      if (!oe_bit) begin
        timer_output_pin <= 1'b0;
      end else if (pwm_bit) begin
        timer_output_pin <= pwm_act_reg ^ inv_bit;
      end else begin
        timer_output_pin <= outff_reg;
      end
      cascade_select <= mode_reg[EBT_CASCADE_BIT];
      run_last_reg   <= run_bit;
    end
  end

  // APB answer: read data registered in setup, ready always high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      if (rd_en) begin
        case (paddr)
          EBT_CLKSEL_OFS: prdata <= {29'h0, clksel_reg};
          EBT_MODE_OFS:   prdata <= {24'h0, mode_reg};
          EBT_CMP_OFS:    prdata <= {24'h0, cmp_reg};
          EBT_CNT_OFS:    prdata <= {24'h0, cnt_reg};
          EBT_STAT_OFS:   prdata <= {31'h0, match_sticky_reg};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  stop_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run_bit |=> cnt_reg == 8'h00)
    else $error("counter not cleared while stopped");

  match_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (match && !pwm_bit) |=> (cnt_reg == 8'h00) && compare_match_interrupt)
    else $error("match did not zero counter and interrupt");

  irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    compare_match_interrupt |-> $past(match) && !$past(pwm_bit))
    else $error("interrupt without match");

  oe_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !oe_bit |=> !timer_output_pin)
    else $error("pin not low with output disabled");

  toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (match && !pwm_bit && inv_bit && !lvs_bit && !lvr_bit) |=> outff_reg != $past(outff_reg))
    else $error("square wave did not toggle");

  level_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lvs_bit && !lvr_bit) |=> outff_reg)
    else $error("level set failed");

  level_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lvr_bit && !lvs_bit) |=> !outff_reg)
    else $error("level clear failed");

  pwm_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!run_bit && pwm_bit && oe_bit) ##1 (pwm_bit && oe_bit) |=>
      timer_output_pin == $past(inv_bit))
    else $error("pwm not inactive while stopped");

  oe_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (oe_bit && !pwm_bit) |=> timer_output_pin == $past(outff_reg))
    else $error("pin does not follow output flip-flop");

  pwm_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (oe_bit && pwm_bit) |=> timer_output_pin == ($past(pwm_act_reg) ^ $past(inv_bit)))
    else $error("pwm active level wrong");

  pwm_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_bit |=> !compare_match_interrupt)
    else $error("interrupt raised in pwm mode");

  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (match && !pwm_bit) |=> match_sticky_reg)
    else $error("match status not set");

  cascade_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> cascade_select == $past(mode_reg[EBT_CASCADE_BIT]))
    else $error("cascade select does not follow mode bit");

  div4_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    t4 |=> (!t4 [*3]) ##1 t4)
    else $error("divide by four tick spacing wrong");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run_bit && tick && cnt_reg != cmp_reg && !pwm_bit) |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter did not step");

  ev_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run_bit && clksel_reg == 3'h1 && !ev_rise) |=> cnt_reg == $past(cnt_reg) || !run_last_reg)
    else $error("counted without an edge");

  interval_c: cover property (@(posedge pclk) disable iff (!presetn)
    compare_match_interrupt ##[1:300] compare_match_interrupt);
  pwm_c: cover property (@(posedge pclk) disable iff (!presetn)
    pwm_bit && oe_bit && $rose(pwm_act_reg));
  event_c: cover property (@(posedge pclk) disable iff (!presetn)
    clksel_reg == 3'h1 && ev_rise && run_bit);
  square_c: cover property (@(posedge pclk) disable iff (!presetn)
    !pwm_bit && inv_bit && oe_bit && $changed(outff_reg));

endmodule

// file: eight_bit_event_timer_tb_top.sv
/*
 * Self-checking bench for the eight-bit event timer channel.
 * Assumes a zero-wait APB slave and the event source partner model.
 */
`timescale 1ns/10ps
module eight_bit_event_timer_tb_top;
  import ebt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, other_ev, ev_go, oth_en;
  logic [7:0]  paddr, ev_n;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, ev_pin, ev_done, tout, cmi, casc;
  int          n_fail, total_checks, cyc, n_int, k0, t0, t1, h, tg;
  logic [31:0] sel_t[6] = '{32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7};
  logic [31:0] n_t[6]   = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h1};
  logic [31:0] per_t[6] = '{32'h2, 32'h4, 32'h8, 32'h80, 32'h100, 32'hA};

  // ==========================================================================
  // Design and partner
  ebt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_input_pin(ev_pin), .other_timer_match_event(other_ev),
    .timer_output_pin(tout), .compare_match_interrupt(cmi), .cascade_select(casc));
  ebt_event_src u_src (.pclk(pclk), .go(ev_go), .npulses(ev_n),
    .event_input_pin(ev_pin), .done(ev_done));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Cycle count, interrupt count, other-timer event every 5 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cmi === 1'b1) n_int <= n_int + 1;
    other_ev <= oth_en && (cyc % 5 == 0);
  end

  // ==========================================================================
  // Bus tasks and checks
  task apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task apb_wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_int(output int t);
    int k;
    k = 0;
    @(posedge pclk);
    while (cmi !== 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      $display("[FAIL] wait_int expected interrupt seen none");
    end
    t = cyc;
  endtask
  // Counts high cycles and transitions of the timer output
  task watch(input int n, output int hi, output int tr);
    logic last;
    hi = 0; tr = 0; last = tout;
    repeat (n) begin
      @(posedge pclk);
      if (tout === 1'b1) hi++;
      if (tout !== last) tr++;
      last = tout;
    end
  endtask
  task pin_is(input string nm, input logic v);
    repeat (3) @(posedge pclk);
    chk(nm, 32'(v), 32'(tout));
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    test_done;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
    ev_go = 0; ev_n = 0; oth_en = 0; other_ev = 0; cyc = 0; n_int = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb_xfer(1'b0, EBT_MODE_OFS, 32'h0); chk("mode_rst", {24'h0, EBT_MODE_RST}, rd);
    apb_xfer(1'b0, EBT_CLKSEL_OFS, 32'h0); chk("clksel_rst", 32'h0, rd);
    chk("pin_rst", 32'h0, 32'(tout));
    apb_wr(8'h14, 32'hFF); apb_xfer(1'b0, 8'h14, 32'h0); chk("unmapped", 32'h0, rd);
    chk("pslverr", 32'h0, 32'(pslverr));
    apb_wr(EBT_CNT_OFS, 32'h55); apb_xfer(1'b0, EBT_CNT_OFS, 32'h0); chk("cnt_ro", 32'h0, rd);
    apb_wr(EBT_MODE_OFS, 32'h10); pin_is("cascade_pin", 1'b0);
    chk("cascade", 32'h1, 32'(casc));
    $display("test reset done");
    // Interval periods for every internal count clock
    oth_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb_wr(EBT_MODE_OFS, 32'h00);
      apb_wr(EBT_CLKSEL_OFS, sel_t[i]);
      apb_wr(EBT_CMP_OFS, n_t[i]);
      apb_wr(EBT_MODE_OFS, 32'h80);
      wait_int(t0);
      wait_int(t1);
      chk("period", per_t[i], 32'(t1 - t0));
    end
    apb_wr(EBT_MODE_OFS, 32'h00);
    apb_xfer(1'b0, EBT_CNT_OFS, 32'h0); chk("cnt_stop", 32'h0, rd);
    apb_xfer(1'b0, EBT_STAT_OFS, 32'h0);
    chk("stat_set", 32'h1, rd);
    apb_wr(EBT_STAT_OFS, 32'h1);
    apb_xfer(1'b0, EBT_STAT_OFS, 32'h0);
    chk("stat_clr", 32'h0, rd);
    oth_en <= 1'b0;
    $display("test interval done");
    // Event counting on falling then rising edges
    for (int m = 0; m < 2; m++) begin
      apb_wr(EBT_MODE_OFS, 32'h00);
      apb_wr(EBT_CLKSEL_OFS, 32'(m));
      apb_wr(EBT_CMP_OFS, 32'h2);
      apb_wr(EBT_MODE_OFS, 32'h80);
      k0 = n_int;
      ev_n <= 8'h05;
      ev_go <= 1'b1;
      for (int k = 0; k < 1000 && ev_done !== 1'b1; k++) @(posedge pclk);
      repeat (6) @(posedge pclk);
      chk("ev_ints", 32'h1, 32'(n_int - k0));
      apb_xfer(1'b0, EBT_CNT_OFS, 32'h0); chk("ev_cnt", 32'h2, rd);
      ev_go <= 1'b0;
    end
    $display("test event done");
    // Square wave, level bits and output enable
    apb_wr(EBT_MODE_OFS, 32'h00); apb_wr(EBT_CLKSEL_OFS, 32'h2); apb_wr(EBT_CMP_OFS, 32'h3);
    apb_wr(EBT_MODE_OFS, 32'h0B); pin_is("lvl_set", 1'b1);
    apb_wr(EBT_MODE_OFS, 32'h03); apb_wr(EBT_MODE_OFS, 32'h83);
    repeat (5) @(posedge pclk);
    watch(80, h, tg);
    chk("sq_high", 32'd40, 32'(h));
    chk("sq_edges", 32'd20, 32'(tg));
    apb_wr(EBT_MODE_OFS, 32'h07); pin_is("lvl_clr", 1'b0);
    apb_wr(EBT_MODE_OFS, 32'h0B); apb_wr(EBT_MODE_OFS, 32'h0A); pin_is("oe_off", 1'b0);
    $display("test square done");
    // PWM active high, then active low, then stop
    apb_wr(EBT_MODE_OFS, 32'h00); apb_wr(EBT_CMP_OFS, 32'd64);
    apb_wr(EBT_MODE_OFS, 32'h41); apb_wr(EBT_MODE_OFS, 32'hC1);
    pin_is("pwm_start", 1'b0);
    repeat (300) @(posedge pclk);
    watch(256, h, tg);
    chk("pwm_high", 32'd64, 32'(h));
    chk("pwm_edges", 32'd2, 32'(tg));
    apb_wr(EBT_MODE_OFS, 32'hC3);
    repeat (3) @(posedge pclk);
    watch(256, h, tg);
    chk("pwm_low", 32'd192, 32'(h));
    apb_wr(EBT_CMP_OFS, 32'd128);
    repeat (300) @(posedge pclk);
    watch(256, h, tg);
    chk("pwm_rewrite", 32'd128, 32'(h));
    apb_wr(EBT_MODE_OFS, 32'h41); pin_is("pwm_stop", 1'b0);
    $display("test pwm done");
    test_done;
  end
endmodule
